// ### sfc_pkg.sv
// Shared constants for the serial flash command port
package sfc_pkg;
	// Opcodes, sent MSB first
	localparam logic [7:0] SFC_OP_WREN  = 8'h06;
	localparam logic [7:0] SFC_OP_WRDI  = 8'h04;
	localparam logic [7:0] SFC_OP_RDSR  = 8'h05;
	localparam logic [7:0] SFC_OP_READ  = 8'h03;
	localparam logic [7:0] SFC_OP_SID   = 8'hAB;
	localparam logic [7:0] SFC_OP_WRSR  = 8'h01;
	localparam logic [7:0] SFC_OP_PROG  = 8'h02;
	localparam logic [7:0] SFC_OP_BULK  = 8'hC7;
	localparam logic [7:0] SFC_OP_SECT  = 8'hD8;
	localparam logic [7:0] SFC_OP_DEVID = 8'h9F;
	// Bytes (opcode included) before read data moves; WRSR gives the exact and PROG the least write frame length
	localparam logic [2:0] SFC_HDR_OP   = 3'h1;
	localparam logic [2:0] SFC_HDR_ADDR = 3'h4;
	localparam logic [2:0] SFC_HDR_SID  = 3'h4;
	localparam logic [2:0] SFC_HDR_DEV  = 3'h3;
	localparam logic [2:0] SFC_HDR_WRSR = 3'h2;
	localparam logic [2:0] SFC_HDR_PROG = 3'h5;
	// Status register fields
	localparam int         SFC_ST_WIP   = 0;
	localparam int         SFC_ST_WEL   = 1;
	localparam int         SFC_ST_BP    = 2;
	localparam int         SFC_PAGE_W   = 8;
	localparam logic [7:0] SFC_ERASED   = 8'hFF;
	// Density variants
	localparam int         SFC_4M_ADDR_W = 19;
	localparam int         SFC_4M_SECT_W = 16;
	localparam int         SFC_1M_ADDR_W = 17;
	localparam int         SFC_1M_SECT_W = 15;
	localparam int         SFC_WSR_CYC   = 16;
	// Controller timing and registers
	localparam int         SFC_SCLK_HALF = 8;
	localparam logic [3:0] SFC_REG_CTRL  = 4'h0;
	localparam logic [3:0] SFC_REG_STAT  = 4'h4;
	localparam int         SFC_CTRL_HOLD = 8;
	localparam int         SFC_CTRL_REL  = 9;
	localparam int         SFC_STAT_BUSY = 0;
	localparam int         SFC_STAT_SEL  = 1;
	localparam int         SFC_STAT_RX   = 8;
endpackage

// ### sfc_link_if.sv
// Four-wire serial link between controller and flash
`timescale 1ns/1ps
interface sfc_link_if;
	logic chip_select_n;
	logic serial_clock_in;
	logic serial_data_in;
	logic serial_data_out;
	modport dev (input chip_select_n, serial_clock_in, serial_data_in, output serial_data_out);
	modport host (output chip_select_n, serial_clock_in, serial_data_in, input serial_data_out);
endinterface

// ### sfc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfc_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk, // System clock
	input  wire logic         rst_b,   // Async reset, low
	input  wire logic [W-1:0] d,       // Asynchronous input
	output logic      [W-1:0] q        // Synchronised output
);
	logic [W-1:0] meta_q;

	// Reset to the pin's idle level, so no false edge follows reset
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
endmodule // sfc_sync

// ### sfc_flash.sv
// Flash end: serial command decode, array, write/erase engine
`timescale 1ns/1ps
// Notes on behaviour
// (R01) All bytes move MSB first
// (R02) Input bits latched on rising serial clock
// (R03) Host holds select until last input bit
// (R04) Reads stream until host raises select
// (R05) Write-type frames must end on byte boundary
// (R06) Busy cycle refuses array access, runs on
// (R07) Write enable sets latch, status bit 1
// (R08) Write disable clears the latch
// (R09) Latch cleared at reset and completion
// (R10) Host sends write enable before each write
// (R11) Read address steps each byte until select rises
// (R12) Status read plain; read has three address
// (R13) Status write one byte; program 1-256 bytes
// (R14) Bulk erase bare; sector erase three address
// (R15) Silicon id after three dummy bytes
// (R16) Device id after two dummy, largest only
// (R17) Over 256 bytes keeps final 256
// (R18) Large variant: eight 64 KB sectors
// (R19) Small variant: four 32 KB sectors
// (R20) Busy bit high during write or erase
// (R21) No write or erase without latch
// (R22) Bulk erase only with protection clear
// (R23) Output changes on falling serial clock
// (R24) Sector erase clears containing sector
module sfc_flash
	import sfc_pkg::*;
#(
	parameter int         ADDR_W    = SFC_4M_ADDR_W, // R18 / R19
	parameter int         SECT_W    = SFC_4M_SECT_W,
	parameter int         BP_W      = 3,
	parameter bit         HAS_SID   = 1'b1,
	parameter bit         HAS_DEVID = 1'b0,
	parameter logic [7:0] SID_BYTE  = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV_BYTE  = 8'hC3, // Arbitrary value
	parameter int         WSR_CYC   = SFC_WSR_CYC
) (
	input  wire logic sys_clk, // 200 MHz system clock
	input  wire logic rst_b,   // Async reset, low
	sfc_link_if.dev   link,    // Serial pins
	output logic      wip,     // Write or erase running
	output logic      wel      // Write enable latch
);
	localparam int NSECT = 1 << (ADDR_W - SECT_W);
	localparam int PAGE  = 1 << SFC_PAGE_W;

	typedef enum logic [3:0] {
		SFC_IDLE  = 4'b0001,
		SFC_PROG  = 4'b0010,
		SFC_ERASE = 4'b0100,
		SFC_WSR   = 4'b1000
	} sfc_eng_t;

	// ------------------------------
	// Pin synchronisers and edges
	// ------------------------------
	logic [2:0] pins_s;
	logic       cs_s, clk_s, di_s, clkp_q, csp_q;
	logic       rise, fall, frame_end;

	// Select idles high, clock and data low
	sfc_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       ({link.chip_select_n, link.serial_clock_in, link.serial_data_in}),
		.q       (pins_s)
	);
	assign {cs_s, clk_s, di_s} = pins_s;

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			clkp_q <= 1'b0;
			csp_q  <= 1'b1;
		end
		else
		begin
			clkp_q <= clk_s;
			csp_q  <= cs_s;
		end

	assign rise      = clk_s & ~clkp_q & ~cs_s; // R02
	assign fall      = ~clk_s & clkp_q & ~cs_s; // R23
	assign frame_end = cs_s & ~csp_q;

	// ------------------------------
	// Input shifting
	// ------------------------------
	logic [2:0]        bit_q, nbyte_q;
	logic [6:0]        sh_q;
	logic [7:0]        op_q, new_byte;
	logic [23:0]       addr_q;
	logic [ADDR_W-1:0] rd_q, wk_q, end_q;
	logic              byte_done;
	logic [7:0]        page_q [PAGE];
	logic [PAGE-1:0]   pval_q;
	logic [7:0]        pptr_q;
	logic [BP_W-1:0]   bp_q;
	logic              wel_q;
	sfc_eng_t          st_q;
	logic [7:0]        status;

	assign new_byte  = {sh_q, di_s}; // R01
	assign byte_done = rise & (bit_q == 3'h7);
	assign status    = 8'({bp_q, wel_q, wip}) ;

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			bit_q   <= '0;
			nbyte_q <= '0;
			sh_q    <= '0;
		end
		else if (cs_s)
		begin
			bit_q   <= '0;
			nbyte_q <= '0;
		end
		else if (rise)
		begin
			bit_q <= bit_q + 3'h1;
			sh_q  <= new_byte[6:0];
			if (bit_q == 3'h7 && nbyte_q != 3'h7)
				nbyte_q <= nbyte_q + 3'h1;
		end

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			op_q   <= '0;
			addr_q <= '0;
		end
		else if (byte_done)
		begin
			if (nbyte_q == 3'h0)
				op_q <= new_byte;
			else if (nbyte_q < SFC_HDR_ADDR)
				addr_q <= {addr_q[15:0], new_byte};
		end

	// Page buffer wraps, so a long burst leaves the final 256 bytes
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			pval_q <= '0;
			pptr_q <= '0;
		end
		else if (byte_done && st_q == SFC_IDLE)
		begin
			if (nbyte_q == 3'h0)
				pval_q <= '0;
			else if (nbyte_q == SFC_HDR_ADDR - 3'h1)
				pptr_q <= new_byte;
			else if (nbyte_q >= SFC_HDR_ADDR && op_q == SFC_OP_PROG)
			begin
				pval_q[pptr_q] <= 1'b1; // R17
				pptr_q         <= pptr_q + 8'h01;
			end
		end

	always_ff @(posedge sys_clk)
		if (byte_done && st_q == SFC_IDLE && nbyte_q >= SFC_HDR_ADDR)
			page_q[pptr_q] <= new_byte; // R13

	// ------------------------------
	// Read output path
	// ------------------------------
	function automatic logic [2:0] hdr_len(input logic [7:0] op);
		unique case (op)
			SFC_OP_RDSR:  hdr_len = SFC_HDR_OP;
			SFC_OP_READ:  hdr_len = SFC_HDR_ADDR;
			SFC_OP_SID:   hdr_len = HAS_SID ? SFC_HDR_SID : 3'h0;
			SFC_OP_DEVID: hdr_len = HAS_DEVID ? SFC_HDR_DEV : 3'h0;
			default:      hdr_len = 3'h0;
		endcase
	endfunction

	logic [7:0]  mem [1 << ADDR_W];
	logic [7:0]  out_byte;
	logic [6:0]  osh_q;
	logic        do_q, rd_act, refused;

	// Busy refuses array and id reads; status stays readable
	assign refused = wip && op_q != SFC_OP_RDSR; // R06
	assign rd_act  = hdr_len(op_q) != 3'h0 && nbyte_q >= hdr_len(op_q); // R04

	always_comb
	begin
		unique case (op_q)
			SFC_OP_RDSR:  out_byte = status; // R12
			SFC_OP_READ:  out_byte = mem[rd_q];
			SFC_OP_SID:   out_byte = SID_BYTE; // R15
			SFC_OP_DEVID: out_byte = DEV_BYTE; // R16
			default:      out_byte = 8'h00;
		endcase
		if (refused)
			out_byte = 8'h00;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			do_q  <= 1'b0;
			osh_q <= '0;
			rd_q  <= '0;
		end
		else if (byte_done && nbyte_q == SFC_HDR_ADDR - 3'h1)
			rd_q <= ADDR_W'({addr_q[15:0], new_byte});
		else if (fall && rd_act)
		begin
			if (bit_q == 3'h0)
			begin
				do_q  <= out_byte[7]; // R11
				osh_q <= out_byte[6:0];
				if (op_q == SFC_OP_READ && !refused)
					rd_q <= rd_q + ADDR_W'(1);
			end
			else
			begin
				do_q  <= osh_q[6];
				osh_q <= {osh_q[5:0], 1'b0};
			end
		end

	assign link.serial_data_out = do_q;

	// ------------------------------
	// Command execution
	// ------------------------------
	function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [BP_W-1:0] bp);
		int span;
		span = (bp == '0) ? 0 : (1 << (int'(bp) - 1));
		is_prot = (int'(a[ADDR_W-1:SECT_W]) + span) >= NSECT;
	endfunction

	logic [ADDR_W-1:0] a_in;
	logic              ok, go_prog, go_sect, go_bulk, go_wsr, done;

	assign a_in    = addr_q[ADDR_W-1:0];
	assign ok      = frame_end && bit_q == 3'h0 && st_q == SFC_IDLE && wel_q; // R05 R21
	assign go_prog = ok && op_q == SFC_OP_PROG && nbyte_q >= SFC_HDR_PROG && !is_prot(a_in, bp_q);
	assign go_sect = ok && op_q == SFC_OP_SECT && nbyte_q == SFC_HDR_ADDR && !is_prot(a_in, bp_q);
	assign go_bulk = ok && op_q == SFC_OP_BULK && nbyte_q == SFC_HDR_OP && bp_q == '0; // R22
	assign go_wsr  = ok && op_q == SFC_OP_WRSR && nbyte_q == SFC_HDR_WRSR;
	assign done    = (st_q == SFC_PROG && wk_q[SFC_PAGE_W-1:0] == '1)
	              || (st_q == SFC_ERASE && wk_q == end_q)
	              || (st_q == SFC_WSR && int'(wk_q) == WSR_CYC - 1);

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			st_q  <= SFC_IDLE;
			wk_q  <= '0;
			end_q <= '0;
		end
		else
		begin
			unique case (st_q)
				SFC_IDLE:
				begin
					wk_q <= '0;
					if (go_prog)
					begin
						st_q <= SFC_PROG;
						wk_q <= {a_in[ADDR_W-1:SFC_PAGE_W], SFC_PAGE_W'(0)};
					end
					else if (go_sect)
					begin
						st_q  <= SFC_ERASE; // R14 R24
						wk_q  <= {a_in[ADDR_W-1:SECT_W], SECT_W'(0)};
						end_q <= {a_in[ADDR_W-1:SECT_W], {SECT_W{1'b1}}};
					end
					else if (go_bulk)
					begin
						st_q  <= SFC_ERASE;
						end_q <= '1;
					end
					else if (go_wsr)
						st_q <= SFC_WSR;
				end
				default:
				begin
					wk_q <= wk_q + ADDR_W'(1); // R06
					if (done)
						st_q <= SFC_IDLE;
				end
			endcase
		end

	always_ff @(posedge sys_clk)
		if (st_q == SFC_PROG && pval_q[wk_q[SFC_PAGE_W-1:0]])
			mem[wk_q] <= mem[wk_q] & page_q[wk_q[SFC_PAGE_W-1:0]];
		else if (st_q == SFC_ERASE)
			mem[wk_q] <= SFC_ERASED;

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			wel_q <= 1'b0; // R09
		else if (done)
			wel_q <= 1'b0; // R09
		else if (frame_end && bit_q == 3'h0 && st_q == SFC_IDLE && nbyte_q == SFC_HDR_OP)
		begin
			if (op_q == SFC_OP_WREN)
				wel_q <= 1'b1; // R07
			else if (op_q == SFC_OP_WRDI)
				wel_q <= 1'b0; // R08
		end

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			bp_q <= '0;
		else if (go_wsr)
			bp_q <= addr_q[SFC_ST_BP +: BP_W];

	assign wip = st_q != SFC_IDLE; // R20
	assign wel = wel_q;
endmodule // sfc_flash

// ### sfc_host.sv
// Controller end: APB byte shifter driving the serial link
`timescale 1ns/1ps
module sfc_host
	import sfc_pkg::*;
#(
	parameter int HALF = SFC_SCLK_HALF
) (
	input  wire logic        sys_clk, // 200 MHz system clock
	input  wire logic        rst_b,   // Async reset, low
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB direction
	input  wire logic [3:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic      [31:0] prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr, // APB error
	sfc_link_if.host         link     // Serial pins
);
	typedef enum logic [4:0] {
		SFC_H_IDLE = 5'b00001,
		SFC_H_LOW  = 5'b00010,
		SFC_H_HIGH = 5'b00100,
		SFC_H_TAIL = 5'b01000,
		SFC_H_GAP  = 5'b10000
	} sfc_host_t;

	sfc_host_t  st_q;
	logic [7:0] tx_q, rx_q;
	logic [2:0] bit_q;
	logic [7:0] div_q;
	logic       hold_q, cs_n_q, sclk_q, din_s;
	logic       setup, wr_ctrl, bad, tick;

	sfc_sync #(.W(1)) u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       (link.serial_data_out),
		.q       (din_s)
	);

	// ------------------------------
	// APB slave, zero wait states
	// ------------------------------
	assign setup   = psel & ~penable;
	assign wr_ctrl = psel & penable & pwrite & paddr == SFC_REG_CTRL;
	// Byte writes while shifting are refused with an error
	assign bad     = (paddr != SFC_REG_CTRL && paddr != SFC_REG_STAT)
	              || (pwrite && (paddr != SFC_REG_CTRL || st_q != SFC_H_IDLE));
	assign pready  = 1'b1;
	assign pslverr = psel & penable & bad;

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			prdata <= '0;
		else if (setup)
		begin
			prdata <= '0;
			if (!pwrite && paddr == SFC_REG_STAT)
			begin
				prdata[SFC_STAT_BUSY]     <= st_q != SFC_H_IDLE;
				prdata[SFC_STAT_SEL]      <= ~cs_n_q;
				prdata[SFC_STAT_RX +: 8] <= rx_q;
			end
		end

	// ------------------------------
	// Serial engine
	// ------------------------------
	assign tick = int'(div_q) == HALF - 1;

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			div_q <= '0;
		else if (st_q == SFC_H_IDLE || tick)
			div_q <= '0;
		else
			div_q <= div_q + 8'h01;

	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			st_q   <= SFC_H_IDLE;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			tx_q   <= '0;
			rx_q   <= '0;
			bit_q  <= '0;
			hold_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				SFC_H_IDLE:
					if (wr_ctrl && pwdata[SFC_CTRL_REL])
						st_q <= SFC_H_TAIL;
					else if (wr_ctrl)
					begin
						st_q   <= SFC_H_LOW;
						cs_n_q <= 1'b0;
						tx_q   <= pwdata[7:0];
						hold_q <= pwdata[SFC_CTRL_HOLD];
						bit_q  <= 3'h7;
					end
				SFC_H_LOW:
					if (tick)
					begin
						st_q   <= SFC_H_HIGH;
						sclk_q <= 1'b1;
						rx_q   <= {rx_q[6:0], din_s}; // R01
					end
				SFC_H_HIGH:
					if (tick)
					begin
						sclk_q <= 1'b0;
						tx_q   <= {tx_q[6:0], 1'b0};
						bit_q  <= bit_q - 3'h1;
						if (bit_q != 3'h0)
							st_q <= SFC_H_LOW;
						else if (hold_q)
							st_q <= SFC_H_IDLE;
						else
							st_q <= SFC_H_TAIL;
					end
				SFC_H_TAIL:
					if (tick)
					begin
						st_q   <= SFC_H_GAP;
						cs_n_q <= 1'b1; // R03 R05
					end
				SFC_H_GAP:
					if (tick)
						st_q <= SFC_H_IDLE;
			endcase
		end

	assign link.chip_select_n   = cs_n_q;
	assign link.serial_clock_in = sclk_q;
	assign link.serial_data_in  = tx_q[7]; // R01
endmodule // sfc_host

// ### sfc_link_assertions.sv
// Protocol checker for the serial flash link
`timescale 1ns/1ps
module sfc_link_assertions (
	input wire logic sys_clk,         // System clock
	input wire logic rst_b,           // Async reset, low
	input wire logic chip_select_n,   // Select, low active
	input wire logic serial_clock_in, // Link clock
	input wire logic serial_data_in,  // Host to flash
	input wire logic serial_data_out, // Flash to host
	input wire logic wip,             // Busy flag
	input wire logic wel              // Write enable latch
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ------------------------------
	// Rising link clocks, modulo 8
	// ------------------------------
	logic       clk_prev_q;
	logic [2:0] bit_cnt_q;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			clk_prev_q <= 1'b0;
		else
			clk_prev_q <= serial_clock_in;
	end
	// Cleared while idle, so it holds the frame's count at select rise
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			bit_cnt_q <= 3'h0;
		else if (chip_select_n)
			bit_cnt_q <= 3'h0;
		else if (serial_clock_in && !clk_prev_q)
			bit_cnt_q <= bit_cnt_q + 3'h1;
	end
	// ------------------------------
	// Properties
	// ------------------------------
	sequence s_frame_end;
		$rose(chip_select_n);
	endsequence
	sequence s_busy_start;
		$rose(wip);
	endsequence
	a_byte_bound: assert property (s_frame_end |-> bit_cnt_q == 3'h0)
		else $error("frame ended off a byte boundary");
	a_busy_after_end: assert property (s_busy_start |-> chip_select_n)
		else $error("busy began inside a frame");
	a_busy_needs_wel: assert property (s_busy_start |-> $past(wel))
		else $error("busy began without write enable");
	a_busy_min_len: assert property (s_busy_start |=> wip [*8])
		else $error("busy flag dropped early");
	a_wel_clr_done: assert property ($fell(wip) |-> !wel)
		else $error("latch survived end of busy");
	a_wel_set_idle: assert property ($rose(wel) |-> chip_select_n)
		else $error("latch set inside a frame");
	a_din_on_low: assert property
		($changed(serial_data_in) && !chip_select_n |-> !serial_clock_in)
		else $error("input data moved while clock high");
	a_dout_on_low: assert property
		($changed(serial_data_out) && !chip_select_n |-> !serial_clock_in)
		else $error("output data moved while clock high");
	a_clk_idle_low: assert property (chip_select_n |-> !serial_clock_in)
		else $error("link clock ran outside a frame");
endmodule // sfc_link_assertions

// ### serial_flash_command_port_tb.sv
// Self-checking bench: controller and flash joined over the link
`timescale 1ns/1ps
module serial_flash_command_port_tb
	import sfc_pkg::*;
;
	localparam logic [7:0] SID_VAL = 8'h5A; // Arbitrary value
	logic        sys_clk;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [3:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        wip;
	logic        wel;
	logic [7:0]  tx[$];
	logic [7:0]  rxq[$];
	int          num_errors;
	int          num_checks;
	sfc_link_if link ();
	sfc_host u_sfc_host (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	// Small array keeps erase times short, still eight sectors
	sfc_flash #(.ADDR_W(13), .SECT_W(10), .SID_BYTE(SID_VAL)) u_sfc_flash (.sys_clk(sys_clk),
		.rst_b(rst_b), .link(link), .wip(wip), .wel(wel));
	sfc_link_assertions u_sfc_link_assertions (.sys_clk(sys_clk), .rst_b(rst_b),
		.chip_select_n(link.chip_select_n), .serial_clock_in(link.serial_clock_in),
		.serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
		.wip(wip), .wel(wel));
	always #2.5 sys_clk = ~sys_clk;
	// ------------------------------
	// Compare and bus tasks
	// ------------------------------
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk1(input string name, input logic exp, input logic got);
		chk8(name, {7'h0, exp}, {7'h0, got});
	endtask
	task automatic apb(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Whole frame from tx; select stays low until the last byte, or on with keep
	task automatic run(input logic keep = 1'b0);
		logic [31:0] rd;
		logic        err;
		rxq = {};
		foreach (tx[i])
		begin
			apb(1'b1, SFC_REG_CTRL, {23'h0, i != tx.size() - 1 || keep, tx[i]}, rd, err);
			do
				apb(1'b0, SFC_REG_STAT, 32'h0, rd, err);
			while (rd[SFC_STAT_BUSY] !== 1'b0);
			rxq.push_back(rd[SFC_STAT_RX +: 8]);
		end
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (wip !== 1'b0 && n < 20000)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk1("wip done", 1'b0, wip);
	endtask
	task automatic read_at(input logic [7:0] lo);
		tx = '{SFC_OP_READ, 8'h00, 8'h00, lo, 8'h00, 8'h00};
		run();
	endtask
	task automatic cmd(input logic [7:0] op);
		tx = '{op};
		run();
	endtask
	task automatic status(input logic [7:0] exp);
		tx = '{SFC_OP_RDSR, 8'h00, 8'h00};
		run();
		chk8("status", exp, rxq[1]);
		chk8("status again", exp, rxq[2]);
	endtask
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset();
		logic [31:0] rd;
		logic        err;
		chk1("wel", 1'b0, wel);
		chk1("select", 1'b1, link.chip_select_n);
		status(8'h00);
		apb(1'b0, 4'h8, 32'h0, rd, err);
		chk1("unmapped err", 1'b1, err);
		chk8("unmapped data", 8'h00, rd[7:0]);
		$display("t_reset done");
	endtask
	task automatic t_latch();
		cmd(SFC_OP_WREN);
		chk1("wel set", 1'b1, wel);
		status(8'h02);
		cmd(SFC_OP_WRDI);
		chk1("wel clear", 1'b0, wel);
		cmd(SFC_OP_WREN);
		chk1("wel before reset", 1'b1, wel);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		chk1("wel after reset", 1'b0, wel);
		chk1("select after reset", 1'b1, link.chip_select_n);
		status(8'h00);
		$display("t_latch done");
	endtask
	// Read left open, then ended by a release-only control write
	task automatic t_sid();
		logic [31:0] rd;
		logic        err;
		tx = '{SFC_OP_SID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		run(1'b1);
		chk8("sid", SID_VAL, rxq[4]);
		chk8("sid repeat", SID_VAL, rxq[5]);
		apb(1'b0, SFC_REG_STAT, 32'h0, rd, err);
		chk1("select held", 1'b1, rd[SFC_STAT_SEL]);
		chk1("select pin held", 1'b0, link.chip_select_n);
		apb(1'b1, SFC_REG_CTRL, 32'h1 << SFC_CTRL_REL, rd, err);
		do
			apb(1'b0, SFC_REG_STAT, 32'h0, rd, err);
		while (rd[SFC_STAT_BUSY] !== 1'b0);
		chk1("select freed", 1'b0, rd[SFC_STAT_SEL]);
		chk1("select pin freed", 1'b1, link.chip_select_n);
		$display("t_sid done");
	endtask
	task automatic t_erase_prog();
		cmd(SFC_OP_WREN);
		tx = '{SFC_OP_SECT, 8'h00, 8'h03, 8'hFF};
		run();
		chk1("erase busy", 1'b1, wip);
		read_at(8'h10);
		chk8("read in busy", 8'h00, rxq[4]);
		wait_done();
		status(8'h00);
		read_at(8'h10);
		chk8("erased", SFC_ERASED, rxq[4]);
		cmd(SFC_OP_WREN);
		tx = '{SFC_OP_PROG, 8'h00, 8'h00, 8'h10, 8'h12, 8'hC6};
		run();
		chk1("prog busy", 1'b1, wip);
		wait_done();
		chk1("wel after prog", 1'b0, wel);
		read_at(8'h10);
		chk8("byte 0", 8'h12, rxq[4]);
		chk8("byte 1", 8'hC6, rxq[5]);
		cmd(SFC_OP_WREN);
		tx = '{SFC_OP_SECT, 8'h00, 8'h04, 8'h00};
		run();
		wait_done();
		read_at(8'h10);
		chk8("other sector", 8'h12, rxq[4]);
		$display("t_erase_prog done");
	endtask
	task automatic t_no_wel();
		tx = '{SFC_OP_PROG, 8'h00, 8'h00, 8'h10, 8'h00};
		run();
		chk1("no busy", 1'b0, wip);
		read_at(8'h10);
		chk8("kept", 8'h12, rxq[4]);
		$display("t_no_wel done");
	endtask
	task automatic t_protect();
		cmd(SFC_OP_WREN);
		tx = '{SFC_OP_WRSR, 8'h04};
		run();
		wait_done();
		status(8'h04);
		cmd(SFC_OP_WREN);
		cmd(SFC_OP_BULK);
		chk1("bulk refused", 1'b0, wip);
		$display("t_protect done");
	endtask
	task automatic close_out();
		$display("Checks made %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------
	// Main sequence and watchdog
	// ------------------------------
	initial
	begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h0;
		num_errors = 0;
		num_checks = 0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_latch();
		t_sid();
		t_erase_prog();
		t_no_wel();
		t_protect();
		close_out();
	end
	// Tests need about 13000 cycles
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		close_out();
	end
endmodule // serial_flash_command_port_tb
